// [tb_wake_event_smi_irq_router.sv]
// Self-checking bench for the wake event routing block
`timescale 1ns/100ps
module tb_wake_event_smi_irq_router;
   import wer_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sw_rst = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] ev_lo = 8'h00;
   logic [7:0] ev_hi = 8'h00;
   logic [7:0] rdata;
   logic mgmt_n;
   logic wk_irq;
   logic irq;
   logic [7:0] mgmt_cnt;
   logic host_irq;
   logic [31:0] seed = 32'h640338EC;
   logic [7:0] en [4];
   logic [7:0] l;
   logic [7:0] h;
   logic [7:0] c0;
   int error_cnt = 0;
   int tests_run = 0;

   wer_router dut (.clock_i(clk), .resetn_i(rst_n), .sw_reset_i(sw_rst),
      .detected_events_lo_i(ev_lo), .detected_events_hi_i(ev_hi), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .system_management_interrupt_n_o(mgmt_n), .wakeup_controller_irq_o(wk_irq), .irq_o(irq));
   wer_host_model host (.clock_i(clk), .resetn_i(rst_n), .mgmt_n_i(mgmt_n), .irq_i(wk_irq),
      .mgmt_cnt_o(mgmt_cnt), .irq_seen_o(host_irq));

   initial begin
      forever #2 clk = ~clk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic hit(input logic [7:0] el, eh, nl, nh);
      return |({eh, el} & {nh, nl & LO_VALID_MASK});
   endfunction

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wrt(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask

   task automatic report_and_stop();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      wrt(OFS_WAKE_CFG, 8'h02);
      for (int i = 0; i < 4; i++) begin
         rdc(OFS_MGMT_LO + 8'(i), ROUTE_RESET);
         wrt(OFS_MGMT_LO + 8'(i), 8'hFF);
         rdc(OFS_MGMT_LO + 8'(i), (i % 2 == 0) ? LO_VALID_MASK : HI_VALID_MASK);
      end
      // Wrong bank and unmapped accesses
      wrt(OFS_WAKE_CFG, 8'h00);
      rdc(OFS_MGMT_HI, 8'h00);
      wrt(OFS_MGMT_HI, 8'h00);
      wrt(OFS_MGMT_LO, 8'h00);
      wrt(OFS_WAKE_CFG, 8'h02);
      rdc(OFS_MGMT_HI, 8'hFF);
      rdc(OFS_MGMT_LO, LO_VALID_MASK);
      rdc(8'h20, 8'h00);
      // Random routing with a reserved-bit corner first
      for (int i = 0; i < 24; i++) begin
         for (int k = 0; k < 4; k++) begin
            en[k] = (i == 0) ? ((k % 2 == 0) ? 8'hFF : 8'h00) : 8'(xs());
            wrt(OFS_MGMT_LO + 8'(k), en[k]);
         end
         l = (i == 0) ? 8'hA0 : 8'(xs());
         h = (i == 0) ? 8'h00 : 8'(xs());
         @(posedge clk);
         ev_lo <= l;
         ev_hi <= h;
         @(posedge clk);
         #1 chk("mgmt_n", 8'(!hit(l, h, en[0], en[1])), 8'(mgmt_n));
         chk("wk_irq", 8'(hit(l, h, en[2], en[3])), 8'(host_irq));
         chk("irq", 8'h00, 8'(irq));
      end
      // Sticky status, mask and clear
      @(posedge clk);
      ev_lo <= 8'h00;
      ev_hi <= 8'h00;
      for (int k = 0; k < 4; k++) begin
         wrt(OFS_MGMT_LO + 8'(k), (k % 2 == 0) ? 8'h01 : 8'h00);
      end
      wrt(OFS_INT_MASK, 8'h01);
      wrt(OFS_INT_STATUS, 8'h03);
      c0 = mgmt_cnt;
      ev_lo <= 8'h01;
      @(posedge clk);
      #1 chk("irq", 8'h01, 8'(irq));
      rdc(OFS_INT_STATUS, 8'h03);
      chk("mgmt_cnt", c0 + 8'h01, mgmt_cnt);
      wrt(OFS_INT_MASK, 8'h00);
      @(posedge clk);
      #1 chk("irq", 8'h00, 8'(irq));
      wrt(OFS_INT_MASK, 8'h01);
      @(posedge clk);
      #1 chk("irq", 8'h01, 8'(irq));
      wrt(OFS_INT_STATUS, 8'h01);
      @(posedge clk);
      #1 chk("irq", 8'h00, 8'(irq));
      rdc(OFS_INT_STATUS, 8'h02);
      // Software reset clears routing
      @(posedge clk);
      sw_rst <= 1'b1;
      @(posedge clk);
      sw_rst <= 1'b0;
      @(posedge clk);
      #1 chk("mgmt_n", 8'h01, 8'(mgmt_n));
      chk("wk_irq", 8'h00, 8'(host_irq));
      rdc(OFS_INT_STATUS, INT_RESET);
      wrt(OFS_WAKE_CFG, 8'h02);
      for (int i = 0; i < 4; i++) begin
         rdc(OFS_MGMT_LO + 8'(i), ROUTE_RESET);
      end
      report_and_stop();
   end
endmodule

// [wer_host_model.sv]
// Host chipset model counting management interrupts
`timescale 1ns/100ps
module wer_host_model (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Lines from the device
   input wire logic mgmt_n_i,
   input wire logic irq_i,
   // Observed activity
   output logic [7:0] mgmt_cnt_o,
   output logic irq_seen_o
);
   logic mgmt_ff;
   logic [7:0] cnt_ff;
   // Count each falling edge of the interrupt
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mgmt_ff <= 1'b1;
         cnt_ff <= 8'h00;
      end else begin
         mgmt_ff <= mgmt_n_i;
         if (mgmt_ff && !mgmt_n_i) begin
            cnt_ff <= cnt_ff + 8'h01;
         end
      end
   end
   assign mgmt_cnt_o = cnt_ff;
   assign irq_seen_o = irq_i;
endmodule

// [wer_pkg.sv]
// Constants shared by the wake event routing block
package wer_pkg;
   // Register port and event vector widths
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned EVT_W = 16;

   // Configuration register and bank select
   localparam logic [7:0] OFS_WAKE_CFG = 8'h04;
   localparam int unsigned CFG_BANK_LSB = 0;
   localparam int unsigned CFG_BANK_MSB = 1;
   localparam logic [1:0] ROUTE_BANK = 2'h2;
   localparam logic [7:0] CFG_VALID_MASK = 8'h03;

   // Routing enable registers (bank 2)
   localparam logic [7:0] OFS_MGMT_LO = 8'h13;
   localparam logic [7:0] OFS_MGMT_HI = 8'h14;
   localparam logic [7:0] OFS_IRQ_LO = 8'h15;
   localparam logic [7:0] OFS_IRQ_HI = 8'h16;

   // Interrupt status and mask, reachable in every bank
   localparam logic [7:0] OFS_INT_STATUS = 8'h05;
   localparam logic [7:0] OFS_INT_MASK = 8'h06;
   localparam int unsigned INT_MGMT_BIT = 0;
   localparam int unsigned INT_IRQ_BIT = 1;
   localparam logic [7:0] INT_VALID_MASK = 8'h03;

   // Low register field positions
   localparam int unsigned BIT_RING_ONE = 0;
   localparam int unsigned BIT_RING_TWO = 1;
   localparam int unsigned BIT_KEYBOARD = 2;
   localparam int unsigned BIT_MOUSE = 3;
   localparam int unsigned BIT_CONSUMER_IR = 4;
   localparam int unsigned BIT_SOFTWARE = 6;
   localparam logic [7:0] LO_VALID_MASK = 8'h5F;
   localparam logic [7:0] HI_VALID_MASK = 8'hFF;

   // Reset values
   localparam logic [7:0] ROUTE_RESET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] INT_RESET = 8'h00;
   localparam logic [7:0] RDATA_IDLE = 8'h00;
endpackage

// [wer_route.sv]
// AND-OR reduction of detected events against routing enables
`timescale 1ns/100ps
module wer_route
   import wer_pkg::*;
(
   // Event flags and enables
   input wire logic [EVT_W-1:0] events_i,
   input wire logic [EVT_W-1:0] enables_i,
   // Routed result
   output logic hit_o
);
   logic [EVT_W-1:0] gated;

   genvar g;
   generate
      for (g = 0; g < EVT_W; g++) begin : g_gate
         assign gated[g] = events_i[g] & enables_i[g];
      end
   endgenerate

   assign hit_o = |gated;
endmodule

// [wer_router.sv]
// Wake event routing to management interrupt and request channel
`timescale 1ns/100ps

// Overview of operation
// - Power-up or software reset clears all four routing enable registers to zero.
// - Management interrupt goes low when any routed event is set, ignoring wake enables.
// - Request channel drives when any routed event is set, ignoring wake enables.
// - Register 13h: software 6, infrared 4, mouse 3, keyboard 2, ring 1, 0.
// - Register 14h holds general input events 7..0 management enables; ring is bits 1, 0 of 13h.
// - Register 15h mirrors 13h layout for requests; bits 7, 5 reserved.
// - Register 16h holds general input events 7..0 request enables.
module wer_router
   import wer_pkg::*;
(
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic sw_reset_i,
   // Detected event flags
   input wire logic [DATA_W-1:0] detected_events_lo_i,
   input wire logic [DATA_W-1:0] detected_events_hi_i,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   // Routed outputs
   output logic system_management_interrupt_n_o,
   output logic wakeup_controller_irq_o,
   output logic irq_o
);
   logic [DATA_W-1:0] mgmt_lo_ff;
   logic [DATA_W-1:0] mgmt_hi_ff;
   logic [DATA_W-1:0] irq_lo_ff;
   logic [DATA_W-1:0] irq_hi_ff;
   logic [DATA_W-1:0] cfg_ff;
   logic [DATA_W-1:0] int_status_ff;
   logic [DATA_W-1:0] int_mask_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic mgmt_n_ff;
   logic route_irq_ff;
   logic intr_ff;

   logic [DATA_W-1:0] nxt_rdata;
   logic [DATA_W-1:0] nxt_int_status;
   logic [DATA_W-1:0] int_set;
   logic [EVT_W-1:0] all_events;
   logic [1:0] bank;
   logic bank_ok;
   logic wr_mgmt_lo;
   logic wr_mgmt_hi;
   logic wr_irq_lo;
   logic wr_irq_hi;
   logic wr_cfg;
   logic wr_status;
   logic wr_mask;
   logic mgmt_hit;
   logic irq_hit;

   assign all_events = {detected_events_hi_i, detected_events_lo_i};
   assign bank = cfg_ff[CFG_BANK_MSB:CFG_BANK_LSB];

   assign bank_ok = (bank == ROUTE_BANK);

   // Write decode
   assign wr_mgmt_lo = reg_wr_i & bank_ok & (reg_addr_i == OFS_MGMT_LO);
   assign wr_mgmt_hi = reg_wr_i & bank_ok & (reg_addr_i == OFS_MGMT_HI);
   assign wr_irq_lo = reg_wr_i & bank_ok & (reg_addr_i == OFS_IRQ_LO);
   assign wr_irq_hi = reg_wr_i & bank_ok & (reg_addr_i == OFS_IRQ_HI);
   assign wr_cfg = reg_wr_i & (reg_addr_i == OFS_WAKE_CFG);
   assign wr_status = reg_wr_i & (reg_addr_i == OFS_INT_STATUS);
   assign wr_mask = reg_wr_i & (reg_addr_i == OFS_INT_MASK);

   // Management interrupt routing
   wer_route u_mgmt_route (
      .events_i(all_events),
      .enables_i({mgmt_hi_ff, mgmt_lo_ff}),
      .hit_o(mgmt_hit)
   );

   // Request channel routing
   wer_route u_irq_route (
      .events_i(all_events),
      .enables_i({irq_hi_ff, irq_lo_ff}),
      .hit_o(irq_hit)
   );

   // Bank select register
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_ff <= CFG_RESET;
      end else if (sw_reset_i) begin
         cfg_ff <= CFG_RESET;
      end else if (wr_cfg) begin
         cfg_ff <= reg_wdata_i & CFG_VALID_MASK;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mgmt_lo_ff <= ROUTE_RESET;
         mgmt_hi_ff <= ROUTE_RESET;
      end else if (sw_reset_i) begin
         mgmt_lo_ff <= ROUTE_RESET;
         mgmt_hi_ff <= ROUTE_RESET;
      end else begin
         if (wr_mgmt_lo) begin
            mgmt_lo_ff <= reg_wdata_i & LO_VALID_MASK;
         end
         if (wr_mgmt_hi) begin
            mgmt_hi_ff <= reg_wdata_i & HI_VALID_MASK;
         end
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_lo_ff <= ROUTE_RESET;
         irq_hi_ff <= ROUTE_RESET;
      end else if (sw_reset_i) begin
         irq_lo_ff <= ROUTE_RESET;
         irq_hi_ff <= ROUTE_RESET;
      end else begin
         if (wr_irq_lo) begin
            irq_lo_ff <= reg_wdata_i & LO_VALID_MASK;
         end
         if (wr_irq_hi) begin
            irq_hi_ff <= reg_wdata_i & HI_VALID_MASK;
         end
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mgmt_n_ff <= 1'b1;
      end else begin
         mgmt_n_ff <= ~mgmt_hit;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         route_irq_ff <= 1'b0;
      end else begin
         route_irq_ff <= irq_hit;
      end
   end

   // Sticky status, set wins over clear
   always_comb begin
      int_set = 8'h00;
      int_set[INT_MGMT_BIT] = mgmt_hit & mgmt_n_ff;
      int_set[INT_IRQ_BIT] = irq_hit & ~route_irq_ff;
      nxt_int_status = int_status_ff;
      if (wr_status) begin
         nxt_int_status = int_status_ff & ~reg_wdata_i;
      end
      nxt_int_status = (nxt_int_status | int_set) & INT_VALID_MASK;
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         int_status_ff <= INT_RESET;
      end else if (sw_reset_i) begin
         int_status_ff <= INT_RESET;
      end else begin
         int_status_ff <= nxt_int_status;
      end
   end

   // Interrupt mask
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         int_mask_ff <= INT_RESET;
      end else if (sw_reset_i) begin
         int_mask_ff <= INT_RESET;
      end else if (wr_mask) begin
         int_mask_ff <= reg_wdata_i & INT_VALID_MASK;
      end
   end

   // Level interrupt output
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         intr_ff <= 1'b0;
      end else begin
         intr_ff <= |(nxt_int_status & int_mask_ff);
      end
   end

   // Read mux, unmapped reads zero
   always_comb begin
      nxt_rdata = RDATA_IDLE;
      if (reg_rd_i) begin
         if (reg_addr_i == OFS_WAKE_CFG) begin
            nxt_rdata = cfg_ff;
         end else if (reg_addr_i == OFS_INT_STATUS) begin
            nxt_rdata = int_status_ff;
         end else if (reg_addr_i == OFS_INT_MASK) begin
            nxt_rdata = int_mask_ff;
         end else if (bank_ok) begin
            unique case (reg_addr_i)
               OFS_MGMT_LO: begin
                  nxt_rdata = mgmt_lo_ff & LO_VALID_MASK;
               end
               OFS_MGMT_HI: begin
                  nxt_rdata = mgmt_hi_ff;
               end
               OFS_IRQ_LO: begin
                  nxt_rdata = irq_lo_ff & LO_VALID_MASK;
               end
               OFS_IRQ_HI: begin
                  nxt_rdata = irq_hi_ff;
               end
               default: begin
                  nxt_rdata = RDATA_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_ff <= RDATA_IDLE;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign system_management_interrupt_n_o = mgmt_n_ff;
   assign wakeup_controller_irq_o = route_irq_ff;
   assign irq_o = intr_ff;

   // Checks
   property p_reset_clear;
      @(posedge clock_i) disable iff (!resetn_i)
      sw_reset_i |=> (mgmt_lo_ff == ROUTE_RESET) && (mgmt_hi_ff == ROUTE_RESET)
         && (irq_lo_ff == ROUTE_RESET) && (irq_hi_ff == ROUTE_RESET);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("Routing enables not cleared");

   property p_mgmt_route;
      @(posedge clock_i) disable iff (!resetn_i)
      (|(all_events & {mgmt_hi_ff, mgmt_lo_ff})) |=> !system_management_interrupt_n_o;
   endproperty
   a_mgmt_route: assert property (p_mgmt_route) else $error("Management interrupt not asserted");

   property p_irq_route;
      @(posedge clock_i) disable iff (!resetn_i)
      wakeup_controller_irq_o == $past(|(all_events & {irq_hi_ff, irq_lo_ff}));
   endproperty
   a_irq_route: assert property (p_irq_route) else $error("Request channel mismatch");

   property p_mgmt_lo_write;
      @(posedge clock_i) disable iff (!resetn_i)
      (wr_mgmt_lo && !sw_reset_i) |=> mgmt_lo_ff == ($past(reg_wdata_i) & LO_VALID_MASK);
   endproperty
   a_mgmt_lo_write: assert property (p_mgmt_lo_write) else $error("Register 13h write wrong");

   property p_mgmt_hi_write;
      @(posedge clock_i) disable iff (!resetn_i)
      (wr_mgmt_hi && !sw_reset_i) |=> mgmt_hi_ff == $past(reg_wdata_i);
   endproperty
   a_mgmt_hi_write: assert property (p_mgmt_hi_write) else $error("Register 14h write wrong");

   property p_irq_lo_write;
      @(posedge clock_i) disable iff (!resetn_i)
      (reg_wr_i && bank == ROUTE_BANK && reg_addr_i == OFS_IRQ_LO && !sw_reset_i)
         |=> irq_lo_ff == ($past(reg_wdata_i) & LO_VALID_MASK);
   endproperty
   a_irq_lo_write: assert property (p_irq_lo_write) else $error("Register 15h write wrong");

   property p_irq_hi_write;
      @(posedge clock_i) disable iff (!resetn_i)
      (reg_wr_i && bank == ROUTE_BANK && reg_addr_i == OFS_IRQ_HI && !sw_reset_i)
         |=> irq_hi_ff == $past(reg_wdata_i);
   endproperty
   a_irq_hi_write: assert property (p_irq_hi_write) else $error("Register 16h write wrong");

   property p_bank_gate;
      @(posedge clock_i) disable iff (!resetn_i)
      (reg_wr_i && bank != ROUTE_BANK && reg_addr_i == OFS_MGMT_LO && !sw_reset_i) |=> $stable(mgmt_lo_ff);
   endproperty
   a_bank_gate: assert property (p_bank_gate) else $error("Routing written outside bank 2");

   property p_reserved_zero;
      @(posedge clock_i) disable iff (!resetn_i)
      (reg_rd_i && (reg_addr_i == OFS_MGMT_LO || reg_addr_i == OFS_IRQ_LO))
         |=> (reg_rdata_o[7] == 1'b0) && (reg_rdata_o[5] == 1'b0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit read as one");
endmodule
